/* rtl/fsch_params.svh */
`ifndef FSCH_PARAMS_SVH
`define FSCH_PARAMS_SVH

// Clock and timing
`define FSCH_CLK_NS      20
`define FSCH_TICK_MS     125
`define FSCH_TICK_CYC    (`FSCH_TICK_MS * 1000000 / `FSCH_CLK_NS)

// APB byte offsets, and the upper address nibbles of the command and response data windows
`define FSCH_A_CTRL      8'h00
`define FSCH_A_CMD       8'h04
`define FSCH_A_RESP      8'h08
`define FSCH_A_STAT      8'h0C
`define FSCH_CDAT_NIB    4'h1
`define FSCH_RDAT_NIB    4'h2
`define FSCH_A_ICLR      8'h30
`define FSCH_A_IEN       8'h34
`define FSCH_A_RPT       8'h38
`define FSCH_A_TRPT      8'h3C
`define FSCH_A_PRES      8'h40

// Control and status bit positions
`define FSCH_CTRL_GO     0
`define FSCH_CTRL_SAVE   1
`define FSCH_RESP_BUSY   16
`define FSCH_ST_DONE     0
`define FSCH_ST_FAN      1
`define FSCH_ST_TEMP     2
`define FSCH_ST_ENUM     3

// Command types and answers
`define FSCH_T_BL        8'h0E
`define FSCH_T_FREP      8'h10
`define FSCH_T_FPWR      8'h11
`define FSCH_T_RDID      8'h12
`define FSCH_T_TREP      8'h13
`define FSCH_T_ARB       8'h14
`define FSCH_ACK         8'h40
`define FSCH_ERR         8'hC0

// Ranges and lengths
`define FSCH_PWR_MAX     8'h64
`define FSCH_FMASK_MAX   8'h0F
`define FSCH_IDX_MAX     8'h1F
`define FSCH_IDX_SKIP    8'h20
`define FSCH_RD_MAX      8'h0E
`define FSCH_LEN1        5'h01
`define FSCH_LEN2        5'h02
`define FSCH_LEN3        5'h03
`define FSCH_LEN4        5'h04
`define FSCH_LEN9        5'h09
`define FSCH_LEN16       5'h10
`define FSCH_ID_LAST     4'h7

// Sensor bus function commands
`define FSCH_MATCH_ROM   8'h55
`define FSCH_SKIP_ROM    8'hCC

`endif

/* rtl/fsch_pkg.sv */
package fsch_pkg;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_DEC   = 7'h02,
    S_RST   = 7'h04,
    S_MATCH = 7'h08,
    S_ADDR  = 7'h10,
    S_WR    = 7'h20,
    S_RD    = 7'h40
  } fsch_state_t;

  typedef enum logic [1:0] {
    OW_RST = 2'h0,
    OW_WR  = 2'h1,
    OW_RD  = 2'h2
  } fsch_owop_t;

  typedef struct packed {
    fsch_state_t       st;
    logic              busy;
    logic [3:0]        cnt;
    logic [6:0]        bl;
    logic [3:0]        fmask;
    logic [3:0][6:0]   flvl;
    logic [3:0][6:0]   fout;
    logic [31:0]       tmask;
    logic [31:0][63:0] ids;
    logic [31:0]       present;
    logic [7:0]        ctype;
    logic [4:0]        clen;
    logic [15:0][7:0]  cdat;
    logic [7:0]        rtype;
    logic [4:0]        rlen;
    logic [15:0][7:0]  rdat;
    logic [3:0]        stat;
    logic [3:0]        ien;
    logic              irq;
    logic [2:0]        eighth;
    logic [1:0]        rpt_fan;
    logic [31:0]       rpt_tmp;
    logic [6:0]        boot_bl;
    logic [3:0][6:0]   boot_f;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              owreq;
    fsch_owop_t        owop;
    logic [7:0]        owwd;
  } fsch_regs_t;

endpackage

/* rtl/fsch_tick_div.sv */
`include "fsch_params.svh"

// Free-running divider, one-cycle enable every DIV clocks
module fsch_tick_div #(
  parameter int unsigned DIV = `FSCH_TICK_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  logic [31:0] cnt_r;
  logic        tick_r;

  // Count to DIV-1 then pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else if (cnt_r == 32'(DIV - 1)) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule // fsch_tick_div

/* rtl/fsch_family_chk.sv */
// Flags a stored family code as a supported temperature sensor
module fsch_family_chk #(
  parameter logic [7:0] FAM_A = 8'hA1,  // arbitrary value
  parameter logic [7:0] FAM_B = 8'hA2   // arbitrary value
) (
  input  wire logic [7:0] family,
  input  wire logic       present,
  output logic            capable
);
  // Either of two family codes qualifies
  assign capable = present && ((family == FAM_A) || (family == FAM_B));
endmodule // fsch_family_chk

/* rtl/fsch_cmd_handler.sv */
`include "fsch_params.svh"

module fsch_cmd_handler #(
  parameter int unsigned TICK_CYC = `FSCH_TICK_CYC,
  parameter logic [7:0]  FAM_A    = 8'hA1,  // arbitrary value
  parameter logic [7:0]  FAM_B    = 8'hA2   // arbitrary value
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 irq,
  output logic      [6:0]      backlight,
  output logic      [3:0][6:0] fan_power,
  output logic      [6:0]      boot_backlight,
  output logic      [3:0][6:0] boot_fan_power,
  output logic                 ow_req,
  output logic      [1:0]      ow_op,
  output logic      [7:0]      ow_wdata,
  input  wire logic            ow_done,
  input  wire logic [7:0]      ow_rdata,
  input  wire logic            enum_valid,
  input  wire logic [4:0]      enum_index,
  input  wire logic [63:0]     enum_id,
  input  wire logic            enum_done
);
  fsch_pkg::fsch_regs_t r, nx;
  logic        tick;
  logic [31:0] cap;
  logic        ok, wsel, save, idle;
  logic [7:0]  d0, d1;
  logic [3:0]  set, clr;
  logic [1:0]  wi, slot;
  logic [31:0] tv;

  fsch_tick_div #(.DIV(TICK_CYC)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // Temperature eligibility per stored device
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_fam
      fsch_family_chk #(.FAM_A(FAM_A), .FAM_B(FAM_B)) u_chk (
        .family  (r.ids[g][7:0]),
        .present (r.present[g]),
        .capable (cap[g])
      );
    end
  endgenerate

  // Next-state logic for the whole block
  always_comb begin
    nx    = r;
    ok    = 1'b0;
    set   = 4'h0;
    clr   = 4'h0;
    save  = 1'b0;
    d0    = r.cdat[0];
    d1    = r.cdat[1];
    wi    = paddr[3:2];
    slot  = 2'h0;
    tv    = r.tmask & cap & r.present;
    idle  = (r.st == fsch_pkg::S_IDLE);
    wsel  = psel & penable & r.pready & pwrite;
    nx.pready = psel & ~penable;
    nx.owreq  = 1'b0;

    // Packet validity check
    case (r.ctype)
      `FSCH_T_BL:   ok = (r.clen == `FSCH_LEN1) && (d0 <= `FSCH_PWR_MAX);
      `FSCH_T_FREP: ok = (r.clen == `FSCH_LEN1) && (d0 <= `FSCH_FMASK_MAX);
      `FSCH_T_FPWR: ok = (r.clen == `FSCH_LEN4) && (d0 <= `FSCH_PWR_MAX)
                      && (d1 <= `FSCH_PWR_MAX) && (r.cdat[2] <= `FSCH_PWR_MAX)
                      && (r.cdat[3] <= `FSCH_PWR_MAX);
      `FSCH_T_RDID: ok = (r.clen == `FSCH_LEN1) && (d0 <= `FSCH_IDX_MAX);
      `FSCH_T_TREP: ok = (r.clen == `FSCH_LEN4);
      `FSCH_T_ARB:  ok = (r.clen >= `FSCH_LEN2) && (r.clen <= `FSCH_LEN16)
                      && (d0 <= `FSCH_IDX_SKIP) && (d1 <= `FSCH_RD_MAX)
                      && ((r.clen > `FSCH_LEN2) || (d1 != 8'h00));
      default:      ok = 1'b0;
    endcase

    // APB read data and error, captured in the setup cycle
    if (psel && !penable) begin
      nx.prdata  = 32'h0;
      nx.pslverr = 1'b0;
      if (paddr[7:4] == `FSCH_CDAT_NIB) begin
        nx.prdata = r.cdat[{wi, 2'b00} +: 4];
      end else if (paddr[7:4] == `FSCH_RDAT_NIB) begin
        nx.prdata = r.rdat[{wi, 2'b00} +: 4];
      end else begin
        case (paddr)
          `FSCH_A_CTRL: nx.prdata = 32'h0;
          `FSCH_A_CMD:  nx.prdata = {19'h0, r.clen, r.ctype};
          `FSCH_A_RESP: nx.prdata = {15'h0, !idle, 3'h0, r.rlen, r.rtype};
          `FSCH_A_STAT: nx.prdata = {28'h0, r.stat};
          `FSCH_A_ICLR: nx.prdata = 32'h0;
          `FSCH_A_IEN:  nx.prdata = {28'h0, r.ien};
          `FSCH_A_RPT:  nx.prdata = {30'h0, r.rpt_fan};
          `FSCH_A_TRPT: nx.prdata = r.rpt_tmp;
          `FSCH_A_PRES: nx.prdata = r.present;
          default:      nx.pslverr = 1'b1;
        endcase
      end
    end

    // APB writes at the access edge
    if (wsel) begin
      if (paddr[7:4] == `FSCH_CDAT_NIB) begin
        if (idle) nx.cdat[{wi, 2'b00} +: 4] = pwdata;
      end else begin
        case (paddr)
          `FSCH_A_CTRL: begin
            if (pwdata[`FSCH_CTRL_GO] && idle) nx.st = fsch_pkg::S_DEC;
            save = pwdata[`FSCH_CTRL_SAVE];
          end
          `FSCH_A_CMD: begin
            if (idle) begin
              nx.ctype = pwdata[7:0];
              nx.clen  = pwdata[12:8];
            end
          end
          `FSCH_A_ICLR: clr = pwdata[3:0];
          `FSCH_A_IEN:  nx.ien = pwdata[3:0];
          default: ;
        endcase
      end
    end

    // Boot state capture
    if (save) begin
      nx.boot_bl = r.bl;
      nx.boot_f  = r.flvl;
    end

    // Identifiers delivered by the power-up enumeration
    if (enum_valid) begin
      nx.ids[enum_index]     = enum_id;
      nx.present[enum_index] = 1'b1;
    end
    if (enum_done) set[`FSCH_ST_ENUM] = 1'b1;

    // Command decode and the sensor bus sequencer
    case (r.st)
      fsch_pkg::S_IDLE: ;
      fsch_pkg::S_DEC: begin
        nx.st    = fsch_pkg::S_IDLE;
        nx.rlen  = 5'h00;
        nx.rtype = `FSCH_ACK | r.ctype;
        set[`FSCH_ST_DONE] = 1'b1;
        if (!ok) begin
          nx.rtype = `FSCH_ERR | r.ctype;
        end else begin
          case (r.ctype)
            `FSCH_T_BL:   nx.bl = d0[6:0];
            `FSCH_T_FREP: nx.fmask = d0[3:0];
            `FSCH_T_FPWR: begin
              for (int i = 0; i < 4; i++) nx.flvl[i] = r.cdat[i][6:0];
            end
            `FSCH_T_RDID: begin
              nx.rlen    = `FSCH_LEN9;
              nx.rdat[0] = d0;
              for (int k = 0; k < 8; k++) nx.rdat[k + 1] = r.ids[d0[4:0]][k * 8 +: 8];
            end
            `FSCH_T_TREP: nx.tmask = {r.cdat[3], r.cdat[2], d1, d0};
            `FSCH_T_ARB: begin
              nx.st   = fsch_pkg::S_RST;
              nx.busy = 1'b0;
              set[`FSCH_ST_DONE] = 1'b0;
            end
            default: ;
          endcase
        end
      end
      default: begin
        // Issue one byte operation, then wait for its completion
        if (!r.busy) begin
          nx.owreq = 1'b1;
          nx.busy  = 1'b1;
          nx.owwd  = 8'h00;
          case (r.st)
            fsch_pkg::S_RST:   nx.owop = fsch_pkg::OW_RST;
            fsch_pkg::S_MATCH: begin
              nx.owop = fsch_pkg::OW_WR;
              nx.owwd = r.present[d0[4:0]] ? `FSCH_MATCH_ROM : `FSCH_SKIP_ROM;
            end
            fsch_pkg::S_ADDR: begin
              nx.owop = fsch_pkg::OW_WR;
              nx.owwd = r.ids[d0[4:0]][{r.cnt[2:0], 3'b000} +: 8];
            end
            fsch_pkg::S_WR: begin
              nx.owop = fsch_pkg::OW_WR;
              nx.owwd = r.cdat[r.cnt + 4'h2];
            end
            default: nx.owop = fsch_pkg::OW_RD;
          endcase
        end else if (ow_done) begin
          nx.busy = 1'b0;
          nx.cnt  = r.cnt + 4'h1;
          case (r.st)
            fsch_pkg::S_RST: begin
              nx.cnt = 4'h0;
              if (d0 != `FSCH_IDX_SKIP) nx.st = fsch_pkg::S_MATCH;
              else if (r.clen > `FSCH_LEN2) nx.st = fsch_pkg::S_WR;
              else nx.st = fsch_pkg::S_RD;
            end
            fsch_pkg::S_MATCH: begin
              nx.cnt = 4'h0;
              if (r.present[d0[4:0]]) nx.st = fsch_pkg::S_ADDR;
              else if (r.clen > `FSCH_LEN2) nx.st = fsch_pkg::S_WR;
              else nx.st = fsch_pkg::S_RD;
            end
            fsch_pkg::S_ADDR: begin
              if (r.cnt == `FSCH_ID_LAST) begin
                nx.cnt = 4'h0;
                nx.st  = (r.clen > `FSCH_LEN2) ? fsch_pkg::S_WR : fsch_pkg::S_RD;
              end
            end
            fsch_pkg::S_WR: begin
              if ({1'b0, r.cnt} == r.clen - `FSCH_LEN3) begin
                nx.cnt = 4'h0;
                if (d1 != 8'h00) begin
                  nx.st = fsch_pkg::S_RD;
                end else begin
                  nx.st    = fsch_pkg::S_IDLE;
                  nx.rtype = `FSCH_ACK | r.ctype;
                  nx.rlen  = 5'h00;
                  set[`FSCH_ST_DONE] = 1'b1;
                end
              end
            end
            default: begin
              nx.rdat[r.cnt] = ow_rdata;
              if ({4'h0, r.cnt} == d1 - 8'h01) begin
                nx.st    = fsch_pkg::S_IDLE;
                nx.rtype = `FSCH_ACK | r.ctype;
                nx.rlen  = d1[4:0];
                set[`FSCH_ST_DONE] = 1'b1;
              end
            end
          endcase
        end
      end
    endcase

    // Report slots: one eighth of a second each
    if (tick) begin
      nx.eighth = r.eighth + 3'h1;
      slot      = nx.eighth[1:0];
      if (r.fmask[slot]) begin
        set[`FSCH_ST_FAN] = 1'b1;
        nx.rpt_fan        = slot;
      end
      if ((nx.eighth == 3'h0) && (tv != 32'h0)) begin
        set[`FSCH_ST_TEMP] = 1'b1;
        nx.rpt_tmp         = tv;
      end
    end

    // Reported fan is forced full on during its own slot
    for (int i = 0; i < 4; i++) begin
      nx.fout[i] = (r.fmask[i] && (r.eighth[1:0] == 2'(i)))
                   ? 7'(`FSCH_PWR_MAX) : r.flvl[i];
    end

    // Sticky status, set wins over clear
    nx.stat = (r.stat & ~clr) | set;
    nx.irq  = |(nx.stat & nx.ien);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r    <= '0;
      r.st <= fsch_pkg::S_IDLE;
    end else begin
      r <= nx;
    end
  end

  // Outputs straight from the state register
  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign irq            = r.irq;
  assign backlight      = r.bl;
  assign fan_power      = r.fout;
  assign boot_backlight = r.boot_bl;
  assign boot_fan_power = r.boot_f;
  assign ow_req         = r.owreq;
  assign ow_op          = r.owop;
  assign ow_wdata       = r.owwd;

  // Checks on decode and sequencing
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_dec_ok(logic [7:0] t);
    (r.st == fsch_pkg::S_DEC) && ok && (r.ctype == t);
  endsequence
  sequence s_rst_done;
    (r.st == fsch_pkg::S_RST) && r.busy && ow_done;
  endsequence

  property p_bl;
    s_dec_ok(`FSCH_T_BL) |=> ({1'b0, r.bl} == $past(d0));
  endproperty
  a_bl: assert property (p_bl) else $error("backlight not loaded");
  property p_ack;
    s_dec_ok(`FSCH_T_BL) |=> (r.rtype == 8'h4E) && (r.rlen == 5'h00) && r.stat[0];
  endproperty
  a_ack: assert property (p_ack) else $error("backlight ack wrong");
  property p_fmask;
    s_dec_ok(`FSCH_T_FREP) |=> ({4'h0, r.fmask} == $past(d0));
  endproperty
  a_fmask: assert property (p_fmask) else $error("fan mask not loaded");
  property p_fpwr;
    s_dec_ok(`FSCH_T_FPWR) |=> ({1'b0, r.flvl[1]} == $past(d1));
  endproperty
  a_fpwr: assert property (p_fpwr) else $error("fan 2 power not loaded");
  property p_ovr;
    (r.fmask[1] && (r.eighth[1:0] == 2'h1)) |=> (r.fout[1] == 7'h64);
  endproperty
  a_ovr: assert property (p_ovr) else $error("fan override missing");
  property p_rpt;
    (tick && (r.eighth == 3'h0) && r.fmask[1]) |=> r.stat[1] && (r.rpt_fan == 2'h1);
  endproperty
  a_rpt: assert property (p_rpt) else $error("fan report missing");
  property p_rej;
    ((r.st == fsch_pkg::S_DEC) && !ok) |=> $stable(r.bl) && $stable(r.fmask)
      && $stable(r.tmask) && $stable(r.flvl) && (r.st == fsch_pkg::S_IDLE);
  endproperty
  a_rej: assert property (p_rej) else $error("bad packet changed state");
  property p_order;
    s_rst_done |=> (r.st == fsch_pkg::S_MATCH) || (r.st == fsch_pkg::S_WR)
      || (r.st == fsch_pkg::S_RD);
  endproperty
  a_order: assert property (p_order) else $error("bad phase after reset");
  property p_skip;
    (s_rst_done ##0 (d0 == `FSCH_IDX_SKIP)) |=> (r.st != fsch_pkg::S_MATCH);
  endproperty
  a_skip: assert property (p_skip) else $error("address phase not skipped");
  property p_rd0;
    (r.st == fsch_pkg::S_RD) |-> (d1 != 8'h00);
  endproperty
  a_rd0: assert property (p_rd0) else $error("read phase with zero count");
  property p_save;
    save |=> (r.boot_bl == $past(r.bl)) && (r.boot_f == $past(r.flvl));
  endproperty
  a_save: assert property (p_save) else $error("boot state not captured");
endmodule // fsch_cmd_handler

/* dv/fsch_bus_model.sv */
// Far side of the sensor bus: answers each byte operation after a wait
module fsch_bus_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ow_req,
  input  wire logic [1:0] ow_op,
  input  wire logic [7:0] ow_wdata,
  output logic            ow_done,
  output logic      [7:0] ow_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] log_q[$];
  logic [2:0] wait_r;
  logic       slow_r;
  logic [7:0] rd_r;

  // Prompt and slow answers alternate; released data line keeps toggling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ow_done  <= 1'b0;
      ow_rdata <= 8'hFF;
      wait_r   <= 3'h0;
      slow_r   <= 1'b0;
      rd_r     <= 8'h30;
    end else begin
      ow_done  <= 1'b0;
      ow_rdata <= ~ow_rdata;
      if (ow_req) begin
        log_q.push_back({ow_op, ow_wdata});
        wait_r <= slow_r ? 3'h5 : 3'h1;
        slow_r <= ~slow_r;
      end else if (wait_r == 3'h1) begin
        ow_done <= 1'b1;
        wait_r  <= 3'h0;
        if (ow_op == 2'h2) begin
          ow_rdata <= rd_r;
          rd_r     <= rd_r + 8'h11;
        end
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule // fsch_bus_model

/* dv/fsch_cmd_handler_test.sv */
`include "fsch_params.svh"

module fsch_cmd_handler_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TK  = 8;
  localparam logic [7:0]  FAM = 8'hA1;  // arbitrary value
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ok;
  logic            ow_req, ow_done, enum_valid, enum_done, rerr;
  logic [1:0]      ow_op;
  logic [4:0]      enum_index;
  logic [6:0]      backlight, boot_backlight;
  logic [7:0]      paddr, ow_wdata, ow_rdata, exp_rd, bl;
  logic [31:0]     pwdata, prdata, rdat, pres, lfsr_r;
  logic [63:0]     enum_id;
  logic [95:0]     v;
  logic [3:0][6:0] fan_power, boot_fan_power, fl;
  logic [63:0]     ids[32];
  logic [7:0]      cb[16];
  int              err_count = 0;
  int              total_checks = 0;
  int              n, c0, c1, c2;

  fsch_cmd_handler #(.TICK_CYC(TK), .FAM_A(FAM)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .backlight, .fan_power, .boot_backlight, .boot_fan_power,
    .ow_req, .ow_op, .ow_wdata, .ow_done, .ow_rdata, .enum_valid, .enum_index,
    .enum_id, .enum_done
  );
  fsch_bus_model u_bus (.pclk, .presetn, .ow_req, .ow_op, .ow_wdata, .ow_done, .ow_rdata);

  // Clock
  always #10 pclk = ~pclk;

  // Checking, reporting and expectation helpers
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic guard(input logic late);
    if (late) begin
      err_count++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  function automatic void rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
  endfunction
  function automatic logic [7:0] ans(input logic [7:0] t, input logic good);
    return good ? (`FSCH_ACK | t) : (`FSCH_ERR | t);
  endfunction

  // Register bus transfer: setup, then access until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    guard(k >= 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full command: load data, type and length, start, wait, fetch answer
  task automatic cmd(input logic [7:0] t, input logic [4:0] len);
    int k;
    apb(1, `FSCH_A_ICLR, 32'h1);
    for (int w = 0; w < 4; w++)
      apb(1, 8'h10 + 8'(4 * w), {cb[4*w+3], cb[4*w+2], cb[4*w+1], cb[4*w]});
    apb(1, `FSCH_A_CMD, {19'h0, len, t});
    apb(1, `FSCH_A_CTRL, 32'h1);
    k = 0;
    do begin
      apb(0, `FSCH_A_STAT, 0);
      k++;
    end while (rdat[0] !== 1'b1 && k < 100);
    guard(k >= 100);
    apb(0, `FSCH_A_RESP, 0);
  endtask

  // Bus transaction and its expected operation log
  task automatic arb(input logic [7:0] idx, input logic [7:0] rc, input logic [4:0] len);
    logic [9:0] q[$];
    logic       hit;
    ok = idx <= 8'h20 && rc <= 8'h0E && len >= 5'h02 && (len > 5'h02 || rc != 0);
    hit = idx < 8'h20 && pres[idx[4:0]];
    cb[0] = idx;
    cb[1] = rc;
    rnd();
    for (int i = 2; i < 16; i++) cb[i] = lfsr_r[7:0] ^ 8'(i * 37);
    u_bus.log_q.delete();
    cmd(`FSCH_T_ARB, len);
    chk(rdat[7:0], ans(`FSCH_T_ARB, ok));
    if (ok) begin
      chk(rdat[12:8], rc[4:0]);
      q.push_back(10'h000);
      if (idx != 8'h20) q.push_back(hit ? 10'h155 : 10'h1CC);
      for (int i = 0; i < 8 && hit; i++) q.push_back({2'h1, ids[idx[4:0]][8*i+:8]});
      for (int i = 2; i < len; i++) q.push_back({2'h1, cb[i]});
      for (int i = 0; i < rc; i++) q.push_back(10'h200);
    end
    chk(u_bus.log_q.size(), q.size());
    foreach (q[i]) chk(q[i][9:8] == 2'h1 ? u_bus.log_q[i] : u_bus.log_q[i] & 10'h300, q[i]);
    for (int i = 0; i < rc && ok; i++) begin
      if (i % 4 == 0) apb(0, 8'h20 + 8'(i), 0);
      chk(rdat[8*(i%4)+:8], exp_rd);
      exp_rd += 8'h11;
    end
  endtask

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, enum_valid, enum_done} = '0;
    {paddr, pwdata, enum_index, enum_id} = '0;
    lfsr_r = 32'hA7A3;
    exp_rd = 8'h30;
    pres = 32'h208;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rnd();
    ids[3] = {lfsr_r, lfsr_r[23:0], FAM};
    ids[9] = {lfsr_r[15:0], lfsr_r, 16'h3710};
    // Enumeration results for devices 3 and 9, driven straight onto the enumeration inputs
    for (int k = 3; k < 10; k += 6) begin
      @(posedge pclk);
      enum_valid <= 1'b1;
      enum_index <= 5'(k);
      enum_id    <= ids[k];
      @(posedge pclk);
      enum_valid <= 1'b0;
    end
    enum_done <= 1'b1;
    @(posedge pclk);
    enum_done <= 1'b0;
    apb(0, `FSCH_A_STAT, 0);
    chk(rdat[3], 1'b1);
    apb(0, `FSCH_A_PRES, 0);
    chk(rdat, pres);
    done("enumeration");
    bl = 8'h00;
    rnd();
    for (int i = 0; i < 5; i++) begin
      cb[0] = i == 0 ? 8'h64 : i == 1 ? 8'h00 : i == 2 ? 8'h65 : 8'(lfsr_r % 99 + 1);
      cmd(`FSCH_T_BL, i == 3 ? `FSCH_LEN2 : `FSCH_LEN1);
      ok = i != 3 && cb[0] <= 8'h64;
      if (ok) bl = cb[0];
      chk(rdat[7:0], ans(`FSCH_T_BL, ok));
      chk(backlight, bl[6:0]);
    end
    for (int i = 0; i < 4; i++) begin
      rnd();
      cb[i] = 8'(lfsr_r % 100);
      fl[i] = cb[i][6:0];
    end
    cmd(`FSCH_T_FPWR, `FSCH_LEN4);
    chk(rdat[12:0], {5'h0, ans(`FSCH_T_FPWR, 1'b1)});
    chk(fan_power, fl);
    cb[2] = 8'h65;
    cmd(`FSCH_T_FPWR, `FSCH_LEN4);
    chk({rdat[7:0], fan_power}, {ans(`FSCH_T_FPWR, 1'b0), fl});
    apb(1, `FSCH_A_CTRL, 32'h2);
    apb(0, `FSCH_A_STAT, 0);
    chk({boot_fan_power, boot_backlight}, {fl, bl[6:0]});
    done("settings");
    cb[0] = 8'h03;
    cmd(`FSCH_T_RDID, `FSCH_LEN1);
    chk(rdat[12:0], {`FSCH_LEN9, ans(`FSCH_T_RDID, 1'b1)});
    v = {24'h0, ids[3], 8'h03};
    for (int w = 0; w < 3; w++) begin
      apb(0, 8'h20 + 8'(4 * w), 0);
      chk(w == 2 ? rdat[7:0] : rdat, v[32*w+:32]);
    end
    cb[0] = 8'h20;
    cmd(`FSCH_T_RDID, `FSCH_LEN1);
    chk(rdat[7:0], ans(`FSCH_T_RDID, 1'b0));
    cmd(8'h15, `FSCH_LEN1);
    chk(rdat[7:0], ans(8'h15, 1'b0));
    done("identifier");
    arb(8'h03, 8'h02, `FSCH_LEN3);
    arb(8'h20, 8'h00, `FSCH_LEN4);
    arb(8'h05, 8'h01, `FSCH_LEN2);
    arb(8'h09, 8'h0E, `FSCH_LEN16);
    arb(8'h20, 8'h00, `FSCH_LEN2);
    arb(8'h21, 8'h01, `FSCH_LEN2);
    arb(8'h20, 8'h0F, `FSCH_LEN2);
    arb(8'h20, 8'h01, `FSCH_LEN1);
    done("bus transactions");
    apb(1, `FSCH_A_IEN, 32'h2);
    cb[0] = 8'h10;
    cmd(`FSCH_T_FREP, `FSCH_LEN1);
    chk(rdat[7:0], ans(`FSCH_T_FREP, 1'b0));
    cb[0] = 8'h03;
    cmd(`FSCH_T_FREP, `FSCH_LEN1);
    chk(rdat[7:0], ans(`FSCH_T_FREP, 1'b1));
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge pclk);
    guard(n >= 200);
    apb(0, `FSCH_A_RPT, 0);
    chk(rdat < 32'h2, 1'b1);
    {c0, c1, c2} = '0;
    repeat (64) begin
      @(posedge pclk);
      c0 += fan_power[0] === 7'h64;
      c1 += fan_power[1] === 7'h64;
      c2 += (fan_power[0] === 7'h64 && fan_power[1] === 7'h64) || fan_power[2] === 7'h64;
    end
    chk({c0[7:0], c1[7:0], c2[7:0]}, 24'h101000);
    apb(1, `FSCH_A_IEN, 32'h0);
    apb(0, `FSCH_A_STAT, 0);
    chk({irq, rdat[1]}, 2'b01);
    cb[0] = 8'h00;
    cmd(`FSCH_T_FREP, `FSCH_LEN1);
    apb(1, `FSCH_A_ICLR, 32'h2);
    apb(1, `FSCH_A_IEN, 32'h2);
    apb(0, `FSCH_A_STAT, 0);
    chk({irq, rdat[1], fan_power}, {2'b00, fl});
    apb(1, `FSCH_A_IEN, 32'h0);
    done("fan reports");
    {cb[3], cb[2], cb[1], cb[0]} = 32'h8;
    cmd(`FSCH_T_TREP, `FSCH_LEN4);
    chk(rdat[7:0], ans(`FSCH_T_TREP, 1'b1));
    n = 0;
    do begin
      apb(0, `FSCH_A_STAT, 0);
      n++;
    end while (rdat[2] !== 1'b1 && n < 100);
    guard(n >= 100);
    apb(0, `FSCH_A_TRPT, 0);
    chk(rdat, 32'h8);
    apb(0, 8'h50, 0);
    chk({rerr, rdat}, 33'h100000000);
    done("temperature");
    end_sim();
  end
endmodule // fsch_cmd_handler_test
